//--- rtl/ccd_engine.sv
// Chop settling and current-detect measurement engine
// Assumes a sample strobe and modulator tick from the same clock domain
//
// Register access over Avalon-MM was decided locally.
`timescale 1ns/1ps
`include "ccd_regs.svh"
module ccd_engine #(
  parameter int CHANNELS = 3
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [15:0] config_word,
  input wire logic [23:0] threshold,
  input wire logic mod_tick,
  input wire logic sample_valid,
  input wire logic [CHANNELS*24-1:0] sample_data,
  output logic detect_event,
  output logic window_event,
  output logic settled_event,
  output ccd_pkg::ccd_engine_s state
);
  // ***********************
  // Decoding helpers
  // ***********************
  function automatic logic [16:0] settle_len(input logic [3:0] code);
    settle_len = 17'h00002 << code;
  endfunction

  function automatic logic [11:0] window_len(input logic [2:0] code);
    unique case (code)
      3'h0: window_len = 12'h080;
      3'h1: window_len = 12'h100;
      3'h2: window_len = 12'h200;
      3'h3: window_len = 12'h300;
      3'h4: window_len = 12'h500;
      3'h5: window_len = 12'h700;
      3'h6: window_len = 12'hA00;
      3'h7: window_len = 12'hE00;
    endcase
  endfunction

  function automatic logic [23:0] magnitude(input logic [23:0] v);
    magnitude = v[23] ? 24'(~v + 24'h000001) : v;
  endfunction

  ccd_pkg::ccd_engine_s st_reg;
  ccd_pkg::ccd_engine_s st_next;
  logic det_p_next;
  logic win_p_next;
  logic set_p_next;
  logic any_over;
  logic all_over;
  logic hit;
  logic [8:0] need;
  logic detect_en;
  logic chop_en;

  // ***********************
  // Next state
  // ***********************
  always_comb
  begin
    st_next = st_reg;
    det_p_next = 1'b0;
    win_p_next = 1'b0;
    set_p_next = 1'b0;
    detect_en = config_word[`CCD_CFG_DETECT_EN];
    chop_en = config_word[`CCD_CFG_CHOP_EN];
    need = 9'h001 << config_word[`CCD_CFG_NUM_LSB +: 3];
    any_over = 1'b0;
    all_over = 1'b1;
    for (int i = 0; i < CHANNELS; i++)
    begin
      if (magnitude(sample_data[i*24 +: 24]) > threshold)
      begin
        any_over = 1'b1;
      end
      else
      begin
        all_over = 1'b0;
      end
    end
    hit = config_word[`CCD_CFG_COMBINE] ? all_over : any_over;
    unique case (st_reg.phase)
      ccd_pkg::CCD_IDLE:
      begin
        st_next.window_cnt = 12'h000;
        st_next.exceed_cnt = 8'h00;
        st_next.detected = 1'b0;
        if (detect_en)
        begin
          st_next.settle_cnt = settle_len(config_word[`CCD_CFG_DLY_LSB +: 4]);
          st_next.phase = chop_en ? ccd_pkg::CCD_SETTLE : ccd_pkg::CCD_MEASURE;
        end
      end
      ccd_pkg::CCD_SETTLE:
      begin
        if (!detect_en)
        begin
          st_next.phase = ccd_pkg::CCD_IDLE;
        end
        else if (mod_tick)
        begin
          st_next.settle_cnt = 17'(st_reg.settle_cnt - 17'h00001);
          if (st_reg.settle_cnt == 17'h00001)
          begin
            set_p_next = 1'b1;
            st_next.phase = ccd_pkg::CCD_MEASURE;
          end
        end
      end
      ccd_pkg::CCD_MEASURE:
      begin
        if (!detect_en)
        begin
          st_next.phase = ccd_pkg::CCD_IDLE;
        end
        else if (sample_valid)
        begin
          if (hit && ({1'b0, st_reg.exceed_cnt} < need))
          begin
            st_next.exceed_cnt = 8'(st_reg.exceed_cnt + 8'h01);
            if (({1'b0, st_reg.exceed_cnt} + 9'h001) == need && !st_reg.detected)
            begin
              st_next.detected = 1'b1;
              det_p_next = 1'b1;
            end
          end
          if ((st_reg.window_cnt + 12'h001) == window_len(config_word[`CCD_CFG_LEN_LSB +: 3]))
          begin
            win_p_next = 1'b1;
            st_next.window_cnt = 12'h000;
            st_next.exceed_cnt = 8'h00;
            st_next.detected = 1'b0;
            st_next.settle_cnt = settle_len(config_word[`CCD_CFG_DLY_LSB +: 4]);
            st_next.phase = chop_en ? ccd_pkg::CCD_SETTLE : ccd_pkg::CCD_MEASURE;
          end
          else
          begin
            st_next.window_cnt = 12'(st_reg.window_cnt + 12'h001);
          end
        end
      end
      default:
      begin
        st_next.phase = ccd_pkg::CCD_IDLE;
      end
    endcase
  end

  // ***********************
  // State register
  // ***********************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_reg <= '{phase: ccd_pkg::CCD_IDLE, settle_cnt: 17'h00000, window_cnt: 12'h000,
                  exceed_cnt: 8'h00, detected: 1'b0};
      detect_event <= 1'b0;
      window_event <= 1'b0;
      settled_event <= 1'b0;
    end
    else
    begin
      st_reg <= st_next;
      detect_event <= det_p_next;
      window_event <= win_p_next;
      settled_event <= set_p_next;
    end
  end

  assign state = st_reg;
endmodule

//--- rtl/ccd_regs.svh
// Register offsets, field positions and reset values of the chop/detect block
// Assumes word-indexed register map, byte address = 4 * index
`ifndef CCD_REGS_SVH
`define CCD_REGS_SVH
`define CCD_IDX_UNUSED5 4'h5
`define CCD_IDX_CONFIG 4'h6
`define CCD_IDX_THR_HIGH 4'h7
`define CCD_IDX_THR_LOW 4'h8
`define CCD_IDX_IRQ_STATUS 4'h9
`define CCD_IDX_IRQ_MASK 4'hA
`define CCD_IDX_STATE 4'hB
`define CCD_RST_UNUSED5 16'h0000
`define CCD_RST_CONFIG 16'h0600
`define CCD_RST_THR_HIGH 16'h0000
`define CCD_RST_THR_LOW 8'h00
`define CCD_CFG_RSVD_MASK 16'h1FFF
`define CCD_CFG_DETECT_EN 0
`define CCD_CFG_LEN_LSB 1
`define CCD_CFG_NUM_LSB 4
`define CCD_CFG_COMBINE 7
`define CCD_CFG_CHOP_EN 8
`define CCD_CFG_DLY_LSB 9
`define CCD_IRQ_DETECT 0
`define CCD_IRQ_WINDOW 1
`define CCD_IRQ_SETTLED 2
`endif

//--- rtl/ccd_pkg.sv
// Types shared by the chop/detect configuration block
// Assumes the register header is included alongside
package ccd_pkg;
  typedef enum logic [1:0] {
    CCD_IDLE = 2'b00,
    CCD_SETTLE = 2'b01,
    CCD_MEASURE = 2'b10
  } ccd_phase_e;

  typedef struct packed {
    logic [15:0] unused5;
    logic [15:0] config_word;
    logic [15:0] thr_high;
    logic [7:0] thr_low;
    logic [2:0] irq_status;
    logic [2:0] irq_mask;
  } ccd_regfile_s;

  typedef struct packed {
    ccd_phase_e phase;
    logic [16:0] settle_cnt;
    logic [11:0] window_cnt;
    logic [7:0] exceed_cnt;
    logic detected;
  } ccd_engine_s;
endpackage

//--- rtl/ccd_top.sv
// Chop and current-detect configuration registers with an Avalon-MM slave
// Assumes word index = address[5:2]; sample inputs on CLK_I
`timescale 1ns/1ps
`include "ccd_regs.svh"
module ccd_top #(
  parameter int CHANNELS = 3
) (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  // Avalon-MM slave
  input wire logic [5:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  input wire logic [3:0] AVS_BYTEENABLE_I,
  output logic [31:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  // Conversion data
  input wire logic MOD_TICK_I,
  input wire logic SAMPLE_VALID_I,
  input wire logic [CHANNELS*24-1:0] SAMPLE_DATA_I,
  // Status
  output logic DETECT_O,
  output logic IRQ_O
);
  typedef struct packed {
    ccd_pkg::ccd_regfile_s rf;
    logic [31:0] rdata;
    logic ack;
    logic irq;
    logic det;
  } ccd_top_s;

  ccd_top_s s_reg;
  ccd_top_s s_next;
  logic [3:0] idx;
  logic [15:0] wd16;
  logic [15:0] cfg_w;
  logic ev_det;
  logic ev_win;
  logic ev_set;
  logic [2:0] events;
  ccd_pkg::ccd_engine_s eng_state;

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] be);
    merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction

  // ***********************
  // Engine
  // ***********************
  ccd_engine #(
    .CHANNELS(CHANNELS)
  ) u_engine (
    .clk(CLK_I),
    .rst(SYS_RST_I),
    .config_word(s_reg.rf.config_word),
    .threshold({s_reg.rf.thr_high, s_reg.rf.thr_low}),
    .mod_tick(MOD_TICK_I),
    .sample_valid(SAMPLE_VALID_I),
    .sample_data(SAMPLE_DATA_I),
    .detect_event(ev_det),
    .window_event(ev_win),
    .settled_event(ev_set),
    .state(eng_state)
  );

  // ***********************
  // Register access
  // ***********************
  always_comb
  begin
    s_next = s_reg;
    idx = AVS_ADDRESS_I[5:2];
    s_next.ack = 1'b0;
    events = 3'b000;
    events[`CCD_IRQ_DETECT] = ev_det;
    events[`CCD_IRQ_WINDOW] = ev_win;
    events[`CCD_IRQ_SETTLED] = ev_set;
    wd16 = 16'h0000;
    cfg_w = 16'h0000;
    if ((AVS_READ_I || AVS_WRITE_I) && !s_reg.ack)
    begin
      s_next.ack = 1'b1;
      if (AVS_WRITE_I)
      begin
        unique case (idx)
          `CCD_IDX_UNUSED5: s_next.rf.unused5 = merge16(s_reg.rf.unused5, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
          `CCD_IDX_CONFIG:
          begin
            cfg_w = merge16(s_reg.rf.config_word, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
            s_next.rf.config_word = cfg_w;
          end
          `CCD_IDX_THR_HIGH: s_next.rf.thr_high = merge16(s_reg.rf.thr_high, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
          `CCD_IDX_THR_LOW:
          begin
            wd16 = merge16({s_reg.rf.thr_low, 8'h00}, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
            s_next.rf.thr_low = wd16[15:8];
          end
          `CCD_IDX_IRQ_MASK: s_next.rf.irq_mask = AVS_BYTEENABLE_I[0] ? AVS_WRITEDATA_I[2:0] : s_reg.rf.irq_mask;
          default: s_next.rf = s_reg.rf;
        endcase
        s_next.rdata = 32'h00000000;
      end
      else
      begin
        unique case (idx)
          `CCD_IDX_UNUSED5: s_next.rdata = {16'h0000, s_reg.rf.unused5};
          `CCD_IDX_CONFIG: s_next.rdata = {16'h0000, s_reg.rf.config_word};
          `CCD_IDX_THR_HIGH: s_next.rdata = {16'h0000, s_reg.rf.thr_high};
          `CCD_IDX_THR_LOW: s_next.rdata = {16'h0000, s_reg.rf.thr_low, 8'h00};
          `CCD_IDX_IRQ_STATUS:
          begin
            s_next.rdata = {29'h00000000, s_reg.rf.irq_status};
            s_next.rf.irq_status = 3'b000;
          end
          `CCD_IDX_IRQ_MASK: s_next.rdata = {29'h00000000, s_reg.rf.irq_mask};
          `CCD_IDX_STATE: s_next.rdata = {8'h00, eng_state.exceed_cnt, 2'b00, eng_state.phase,
                                          eng_state.window_cnt};
          default: s_next.rdata = 32'h00000000;
        endcase
      end
    end
    // Set wins over read-clear
    s_next.rf.irq_status = s_next.rf.irq_status | events;
    s_next.irq = |(s_next.rf.irq_status & s_next.rf.irq_mask);
    s_next.det = eng_state.detected;
  end

  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
    begin
      s_reg <= '{rf: '{unused5: `CCD_RST_UNUSED5, config_word: `CCD_RST_CONFIG, thr_high: `CCD_RST_THR_HIGH,
                       thr_low: `CCD_RST_THR_LOW, irq_status: 3'b000, irq_mask: 3'b000},
                 rdata: 32'h00000000, ack: 1'b0, irq: 1'b0, det: 1'b0};
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // ***********************
  // Outputs
  // ***********************
  assign AVS_READDATA_O = s_reg.rdata;
  assign AVS_WAITREQUEST_O = !s_reg.ack;
  assign DETECT_O = s_reg.det;
  assign IRQ_O = s_reg.irq;
endmodule

//--- verification/ccd_top_sva.sv
// Checker for the chop/detect register block
// Assumes binding to ccd_top, one clock
`timescale 1ns/1ps
module ccd_top_sva (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  // Bus and status
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_READDATA_O,
  input wire logic AVS_WAITREQUEST_O,
  input wire logic SAMPLE_VALID_I,
  input wire logic DETECT_O,
  input wire logic IRQ_O
);
  // ****
  // Properties
  // ****
  logic rq1;
  logic rq2;
  logic rd1;
  logic s1;
  logic s2;
  logic s3;
  always_ff @(posedge CLK_I)
  begin
    rq1 <= AVS_READ_I | AVS_WRITE_I;
    rq2 <= rq1;
    rd1 <= AVS_READ_I;
    s1 <= SAMPLE_VALID_I;
    s2 <= s1;
    s3 <= s2;
  end
  default clocking @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);
  take_ack_a: assert property ((AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O)
    else $error("request not answered");
  ack_pulse_a: assert property (!AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property (!AVS_WAITREQUEST_O |-> rq1)
    else $error("ack without request");
  rdata_hold_a: assert property (AVS_WAITREQUEST_O |-> $stable(AVS_READDATA_O))
    else $error("read data moved");
  upper_zero_a: assert property (!AVS_WAITREQUEST_O && rd1 |-> AVS_READDATA_O[31:16] == 16'h0000)
    else $error("upper read bits set");
  reset_idle_a: assert property ($fell(SYS_RST_I) |-> AVS_WAITREQUEST_O && !IRQ_O && !DETECT_O)
    else $error("outputs not idle after reset");
  irq_clear_a: assert property ($fell(IRQ_O) |-> rq1 || rq2)
    else $error("irq fell without access");
  detect_cause_a: assert property ($rose(DETECT_O) |-> s1 || s2 || s3)
    else $error("detect without sample");
  cover property (AVS_WRITE_I && !AVS_WAITREQUEST_O);
  cover property (AVS_READ_I && !AVS_WAITREQUEST_O);
  cover property ($rose(IRQ_O));
  cover property ($rose(DETECT_O));
endmodule
bind ccd_top ccd_top_sva u_sva (
  .CLK_I(CLK_I),
  .SYS_RST_I(SYS_RST_I),
  .AVS_READ_I(AVS_READ_I),
  .AVS_WRITE_I(AVS_WRITE_I),
  .AVS_READDATA_O(AVS_READDATA_O),
  .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
  .SAMPLE_VALID_I(SAMPLE_VALID_I),
  .DETECT_O(DETECT_O),
  .IRQ_O(IRQ_O)
);

//--- verification/ccd_top_tb_top.sv
// Testbench for the chop/detect register block
// Assumes ccd_top with three channels
`timescale 1ns/1ps
module ccd_top_tb_top;
  // ****
  // Stimulus and checks
  // ****
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [5:0] adr = 6'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [3:0] be = 4'h3;
  logic [31:0] rdat;
  logic wreq;
  logic tick = 1'b0;
  logic sv = 1'b0;
  logic [71:0] sd = 72'h0;
  logic det;
  logic irq;
  logic [31:0] v;
  int error_cnt = 0;
  int total_checks = 0;
  localparam logic [23:0] HI = 24'h00012C;
  localparam logic [23:0] NG = 24'hFFFED4;
  localparam logic [23:0] LO = 24'h00000A;
  ccd_top u_dut (
    .CLK_I(clk),
    .SYS_RST_I(rst),
    .AVS_ADDRESS_I(adr),
    .AVS_READ_I(rd),
    .AVS_WRITE_I(wr),
    .AVS_WRITEDATA_I(wd),
    .AVS_BYTEENABLE_I(be),
    .AVS_READDATA_O(rdat),
    .AVS_WAITREQUEST_O(wreq),
    .MOD_TICK_I(tick),
    .SAMPLE_VALID_I(sv),
    .SAMPLE_DATA_I(sd),
    .DETECT_O(det),
    .IRQ_O(irq)
  );
  initial
  begin
    forever #12.5 clk = ~clk;
  end
  task automatic results;
    if (error_cnt == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("ERROR %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [3:0] i, input logic [15:0] d);
    int n;
    n = 0;
    adr <= {i, 2'b00};
    wd <= {16'h0000, d};
    rd <= !w;
    wr <= w;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wreq !== 1'b0 && n < 20);
    if (n >= 20)
    begin
      error_cnt++;
      $display("ERROR %0t no bus answer", $time);
    end
    v = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic cfg(input logic [15:0] d);
    acc(1, 4'h6, 16'h0000);
    acc(0, 4'h9, 16'h0000);
    acc(1, 4'h6, d);
  endtask
  task automatic smp(input int k, input logic [23:0] a, input logic [23:0] b, input logic [23:0] c);
    repeat (k)
    begin
      sv <= 1'b1;
      sd <= {c, b, a};
      @(posedge clk);
      sv <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask
  initial
  begin
    #500000;
    error_cnt++;
    $display("ERROR %0t watchdog expired", $time);
    results();
  end
  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    acc(0, 4'h5, 16'h0000);
    chk(v, 32'h0000);
    acc(0, 4'h6, 16'h0000);
    chk(v, 32'h0600);
    acc(0, 4'h7, 16'h0000);
    chk(v, 32'h0000);
    acc(1, 4'h5, 16'h0000);
    acc(0, 4'h5, 16'h0000);
    chk(v, 32'h0000);
    acc(1, 4'h6, 16'h1FFF);
    acc(0, 4'h6, 16'h0000);
    chk(v, 32'h1FFF);
    acc(1, 4'h7, 16'hA5C3);
    be <= 4'h1;
    acc(1, 4'h7, 16'h1111);
    be <= 4'h3;
    acc(0, 4'h7, 16'h0000);
    chk(v, 32'hA511);
    acc(1, 4'h3, 16'hFFFF);
    acc(0, 4'h3, 16'h0000);
    chk(v, 32'h0000);
    acc(1, 4'h8, 16'h5A00);
    acc(0, 4'h8, 16'h0000);
    chk(v, 32'h5A00);
    acc(1, 4'h7, 16'h0001);
    acc(1, 4'h8, 16'h0000);
    acc(1, 4'hA, 16'h0001);
    acc(0, 4'hA, 16'h0000);
    chk(v, 32'h0001);
    cfg(16'h0000);
    smp(2, HI, HI, HI);
    chk({30'h0, det, irq}, 32'h0);
    cfg(16'h0001);
    smp(1, LO, NG, LO);
    chk({30'h0, det, irq}, 32'h3);
    acc(0, 4'h9, 16'h0000);
    chk(v, 32'h0001);
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    smp(126, LO, LO, LO);
    acc(0, 4'h9, 16'h0000);
    chk(v, 32'h0000);
    smp(1, LO, LO, LO);
    chk({31'h0, irq}, 32'h0);
    acc(0, 4'h9, 16'h0000);
    chk(v, 32'h0002);
    cfg(16'h0021);
    smp(3, HI, LO, LO);
    chk({31'h0, det}, 32'h0);
    smp(1, HI, LO, LO);
    chk({31'h0, det}, 32'h1);
    cfg(16'h0081);
    smp(2, HI, LO, LO);
    chk({31'h0, det}, 32'h0);
    smp(1, HI, NG, HI);
    chk({31'h0, det}, 32'h1);
    cfg(16'h0101);
    smp(1, HI, HI, HI);
    chk({31'h0, det}, 32'h0);
    repeat (2)
    begin
      tick <= 1'b1;
      @(posedge clk);
      tick <= 1'b0;
      @(posedge clk);
    end
    smp(1, HI, HI, HI);
    chk({31'h0, det}, 32'h1);
    acc(0, 4'h9, 16'h0000);
    chk(v, 32'h0005);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk({30'h0, det, irq}, 32'h0);
    acc(0, 4'h6, 16'h0000);
    chk(v, 32'h0600);
    acc(0, 4'h7, 16'h0000);
    chk(v, 32'h0000);
    results();
  end
endmodule
